// >>> logic/ddp_pin_core.sv
// Pin behaviour of a byte-wide DDR DRAM: commands, termination, data and strobes.
// Assumes all pins are synchronous to clk_sys_i and the controller obeys burst timing.
`timescale 1ns/1ps
module ddp_pin_core
  import ddp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Configuration strap
  input wire logic byte_wide_i,
  // Differential clock pins
  input wire logic diff_clock_true_i,
  input wire logic diff_clock_comp_i,
  // Command and address pins
  input wire ddp_cmd_pins_t cmd_pins_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [BANK_W-1:0] bank_i,
  input wire logic termination_enable_i,
  // Data pins
  input wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0] dq_o,
  output logic [DATA_W-1:0] dq_oe_o,
  input wire logic dqs_i,
  output logic dqs_o,
  output logic dqs_n_o,
  output logic dqs_oe_o,
  input wire logic write_mask_i,
  output logic term_strobe_o,
  output logic term_strobe_n_o,
  output logic term_strobe_oe_o,
  // Termination control
  output ddp_term_t term_o,
  // Array side
  output ddp_beat_t wr_beat_o,
  input wire logic [DATA_W-1:0] rd_data_i,
  output logic rd_take_o,
  output ddp_cmd_t cmd_o,
  output logic cmd_valid_o
);

  logic true_rise;
  logic comp_fall;
  logic crossing;
  logic dqs_edge;
  ddp_cmd_t cmd_dec;
  logic strap_done_q;
  logic byte_wide_q;
  logic term_dis_q;
  logic strobe_en_q;
  logic odt_q;
  ddp_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  ddp_beat_t beat_q;
  logic [DATA_W-1:0] dq_q;
  logic dqs_q;
  logic drive_q;
  ddp_term_t term_d;
  ddp_term_t term_q;
  logic [DATA_W-1:0] lane_en;
  ddp_cmd_t cmd_q;
  logic cmd_valid_q;

  ddp_edge_det #(.RISE(1'b1), .FALL(1'b0)) u_true_rise (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .sig_i(diff_clock_true_i),
    .edge_o(true_rise)
  );

  ddp_edge_det #(.RISE(1'b0), .FALL(1'b1)) u_comp_fall (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .sig_i(diff_clock_comp_i),
    .edge_o(comp_fall)
  );

  ddp_edge_det #(.RISE(1'b1), .FALL(1'b1)) u_dqs_edge (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .sig_i(dqs_i),
    .edge_o(dqs_edge)
  );

  ddp_cmd_dec u_cmd_dec (
    .pins_i(cmd_pins_i),
    .cmd_o(cmd_dec)
  );

  // Command sampling point
  assign crossing = true_rise & comp_fall;

  // Strap caught at first edge after reset release
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_done_q <= 1'b0;
      byte_wide_q <= BYTE_WIDE_RST;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      byte_wide_q <= byte_wide_i;
    end
  end

  // Registered command
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_q <= CMD_DESEL;
      cmd_valid_q <= 1'b0;
    end else begin
      cmd_valid_q <= crossing & (cmd_dec != CMD_DESEL);
      if (crossing) begin
        cmd_q <= cmd_dec;
      end
    end
  end

  assign cmd_o = cmd_q;
  assign cmd_valid_o = cmd_valid_q;

  // Mode-load termination controls
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      term_dis_q <= TERM_DIS_RST;
      strobe_en_q <= STROBE_EN_RST;
    end else if (crossing && cmd_dec == CMD_MODE && bank_i == MR_TERM_BANK) begin
      term_dis_q <= addr_i[TERM_DIS_BIT];
      strobe_en_q <= addr_i[STROBE_EN_BIT] & byte_wide_q;
    end
  end

  // Termination enable registered at the crossing
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      odt_q <= 1'b0;
    end else if (crossing) begin
      odt_q <= termination_enable_i;
    end
  end

  assign lane_en = byte_wide_q ? 8'hff : 8'h0f;

  always_comb begin
    term_d = '0;
    if (odt_q && !term_dis_q) begin
      term_d.dq = lane_en;
      term_d.dqs = 1'b1;
      term_d.dqs_n = 1'b1;
      term_d.mask = 1'b1;
      term_d.strobe_n = strobe_en_q;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      term_q <= '0;
    end else begin
      term_q <= term_d;
    end
  end

  assign term_o = term_q;

  // Burst sequencer
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          cnt_q <= '0;
          if (crossing && cmd_dec == CMD_WRITE) begin
            state_q <= ST_WRITE;
          end else if (crossing && cmd_dec == CMD_READ) begin
            state_q <= ST_READ;
          end
        end
        ST_WRITE: begin
          if (dqs_edge) begin
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == CNT_LAST) begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_READ: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == CNT_LAST) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Write capture on each strobe edge
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      beat_q <= '0;
    end else begin
      beat_q.valid <= 1'b0;
      if (state_q == ST_WRITE && dqs_edge) begin
        beat_q.data <= dq_i & lane_en;
        beat_q.valid <= !(write_mask_i && !strobe_en_q);
      end
    end
  end

  assign wr_beat_o = beat_q;

  // Read drive: data and strobe change together
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dq_q <= '0;
      dqs_q <= 1'b0;
      drive_q <= 1'b0;
    end else begin
      drive_q <= (state_q == ST_READ);
      if (state_q == ST_READ) begin
        dq_q <= rd_data_i & lane_en;
        dqs_q <= ~dqs_q;
      end else begin
        dqs_q <= 1'b0;
      end
    end
  end

  assign rd_take_o = (state_q == ST_READ);
  assign dq_o = dq_q;
  assign dq_oe_o = drive_q ? lane_en : 8'h00;
  assign dqs_o = dqs_q;
  assign dqs_n_o = ~dqs_q;
  assign dqs_oe_o = drive_q;
  // Strobe balls never drive; only the complement ball terminates, and only with strobe mode on
  assign term_strobe_o = 1'b0;
  assign term_strobe_n_o = 1'b0;
  assign term_strobe_oe_o = 1'b0;

  sequence cross_s;
    crossing;
  endsequence

  sequence read_cmd_s;
    crossing && cmd_dec == CMD_READ && state_q == ST_IDLE;
  endsequence

  sequence write_cmd_s;
    crossing && cmd_dec == CMD_WRITE && state_q == ST_IDLE;
  endsequence

  mask_drop_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    state_q == ST_WRITE && dqs_edge && write_mask_i && !strobe_en_q |=> !beat_q.valid)
    else $error("masked write byte was kept");

  strobe_mode_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    state_q == ST_WRITE && dqs_edge && strobe_en_q |=> beat_q.valid)
    else $error("mask applied while strobe mode on");

  term_follow_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    cross_s ##0 (termination_enable_i && !term_dis_q && cmd_dec != CMD_MODE)
      |=> ##1 (term_o.dqs && term_o.mask))
    else $error("termination did not follow enable");

  term_ignore_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    term_dis_q && $past(term_dis_q) |-> ##1 term_o == '0)
    else $error("termination on while disabled");

  cs_mask_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    crossing && cmd_pins_i.cs_n |=> !cmd_valid_o && ($past(state_q) != ST_IDLE || state_q == ST_IDLE))
    else $error("command taken with chip select high");

  read_burst_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    read_cmd_s |=> ##1 (dqs_oe_o && dqs_o) ##1 (dqs_oe_o && !dqs_o))
    else $error("read strobe not toggling with data");

  read_len_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    read_cmd_s |=> rd_take_o [*8] ##1 !rd_take_o)
    else $error("read burst length wrong");

  write_start_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    write_cmd_s |=> state_q == ST_WRITE && !dqs_oe_o)
    else $error("write burst not entered");

  narrow_lane_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !byte_wide_q |-> dq_oe_o[7:4] == 4'h0 && !term_o.strobe_n && term_o.dq[7:4] == 4'h0)
    else $error("upper balls active in four-bit mode");

  sample_point_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !crossing |=> $stable(odt_q) && !cmd_valid_o)
    else $error("pins sampled outside crossing");

  reset_state_a: assert property (@(posedge clk_sys_i)
    !rst_n_i |-> state_q == ST_IDLE && !dqs_oe_o && term_o == '0)
    else $error("state not cleared by reset");

endmodule

// >>> inc/ddp_pkg.sv
// Constants, command codes and carrier types of the byte-wide DRAM pin block.
// Assumes one system clock that samples every pin synchronously.
package ddp_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned HALF_W = 4;
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned BANK_W = 3;
  localparam int unsigned BEATS = 8;
  localparam int unsigned CNT_W = 3;

  // Mode-load slot that carries the termination controls
  localparam logic [BANK_W-1:0] MR_TERM_BANK = 3'h1;
  localparam int unsigned TERM_DIS_BIT = 0;
  localparam int unsigned STROBE_EN_BIT = 11;
  localparam logic TERM_DIS_RST = 1'b0;
  localparam logic STROBE_EN_RST = 1'b0;
  localparam logic BYTE_WIDE_RST = 1'b1;
  localparam logic [CNT_W-1:0] CNT_LAST = 3'h7;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } ddp_cmd_pins_t;

  typedef enum logic [3:0] {
    CMD_DESEL,
    CMD_NOP,
    CMD_ACT,
    CMD_READ,
    CMD_WRITE,
    CMD_PRE,
    CMD_REF,
    CMD_MODE,
    CMD_ZQ
  } ddp_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WRITE,
    ST_READ
  } ddp_state_t;

  typedef struct packed {
    logic [DATA_W-1:0] dq;
    logic dqs;
    logic dqs_n;
    logic mask;
    logic strobe_n;
  } ddp_term_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic valid;
  } ddp_beat_t;

endpackage

// >>> logic/ddp_edge_det.sv
// Edge detector for a pin already synchronous to the system clock.
// Assumes the pin is sampled once per system clock.
`timescale 1ns/1ps
module ddp_edge_det #(
  parameter bit RISE = 1'b1,
  parameter bit FALL = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Pin and event
  input wire logic sig_i,
  output logic edge_o
);

  logic prev_q;
  logic seen_q;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      prev_q <= sig_i;
      seen_q <= 1'b1;
    end
  end

  // No edge until the pin was sampled once after reset
  assign edge_o = seen_q & ((RISE & sig_i & ~prev_q) | (FALL & ~sig_i & prev_q));

endmodule

// >>> logic/ddp_cmd_dec.sv
// Command decoder for the four command pins.
// Assumes the pins are sampled at the clock crossing by the caller.
`timescale 1ns/1ps
module ddp_cmd_dec
  import ddp_pkg::*;
(
  // Sampled pins
  input wire ddp_cmd_pins_t pins_i,
  // Decoded command
  output ddp_cmd_t cmd_o
);

  always_comb begin
    if (pins_i.cs_n) begin
      cmd_o = CMD_DESEL;
    end else begin
      case ({pins_i.ras_n, pins_i.cas_n, pins_i.we_n})
        3'h7: cmd_o = CMD_NOP;
        3'h3: cmd_o = CMD_ACT;
        3'h5: cmd_o = CMD_READ;
        3'h4: cmd_o = CMD_WRITE;
        3'h2: cmd_o = CMD_PRE;
        3'h1: cmd_o = CMD_REF;
        3'h0: cmd_o = CMD_MODE;
        3'h6: cmd_o = CMD_ZQ;
        default: cmd_o = CMD_NOP;
      endcase
    end
  end

endmodule

// >>> verification/ddp_ctrl_model.sv
// Controller model: clock pins, commands, termination enable, write data.
// Assumes the bench calls its tasks one at a time from one process.
`timescale 1ns/1ps
module ddp_ctrl_model
  import ddp_pkg::*;
(
  // Clock
  input wire logic clk_sys_i,
  // Controller pins
  output logic diff_clock_true_o,
  output logic diff_clock_comp_o,
  output ddp_cmd_pins_t cmd_pins_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [BANK_W-1:0] bank_o,
  output logic termination_enable_o,
  output logic [DATA_W-1:0] dq_o,
  output logic dqs_o,
  output logic write_mask_o
);
  initial begin
    diff_clock_true_o = 1'b1;
    diff_clock_comp_o = 1'b0;
    cmd_pins_o = 4'hf;
    addr_o = 14'h0000;
    bank_o = 3'h0;
    termination_enable_o = 1'b0;
    dq_o = 8'h00;
    dqs_o = 1'b0;
    write_mask_o = 1'b0;
  end

  // One command at a single true-rise crossing
  task automatic cmd(input logic [3:0] p, input logic [ADDR_W-1:0] a,
                     input logic [BANK_W-1:0] b, input logic termination_enable);
    @(negedge clk_sys_i);
    diff_clock_true_o = 1'b0;
    diff_clock_comp_o = 1'b1;
    @(negedge clk_sys_i);
    diff_clock_true_o = 1'b1;
    diff_clock_comp_o = 1'b0;
    cmd_pins_o = p;
    addr_o = a;
    bank_o = b;
    termination_enable_o = termination_enable;
    @(negedge clk_sys_i);
    cmd_pins_o = 4'hf;
    addr_o = ~a;
  endtask

  // Eight beats, strobe toggled one cycle after data settles
  task automatic wr(input logic [DATA_W-1:0] base, input logic [BEATS-1:0] msk);
    for (int i = 0; i < BEATS; i++) begin
      @(negedge clk_sys_i);
      dq_o = base + DATA_W'(i);
      write_mask_o = msk[i];
      @(negedge clk_sys_i);
      dqs_o = ~dqs_o;
    end
    @(negedge clk_sys_i);
    dq_o = ~dq_o;
    write_mask_o = ~write_mask_o;
  endtask
endmodule

// >>> verification/tb_dram_x8_pin_behaviour.sv
// Bench for the pin core with a controller model on the far side.
// Assumes one 100 MHz clock; array read data comes from a counter.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module tb_dram_x8_pin_behaviour;
  import ddp_pkg::*;
  logic clk_sys_i, rst_n_i, byte_wide, ct, cc, termination_enable, wm, c_dqs, dqs_w;
  logic d_dqs, d_dqs_n, d_dqs_oe, ts, tsn, tsoe, rd_take, cmd_valid;
  ddp_cmd_pins_t pins;
  logic [ADDR_W-1:0] addr;
  logic [BANK_W-1:0] bank;
  logic [DATA_W-1:0] c_dq, d_dq, d_dq_oe, dq_w, rd_data, nrd;
  ddp_term_t term;
  ddp_beat_t beat;
  ddp_cmd_t cmd;
  int n_mismatch, checked;
  logic [7:0] rq[$], wq[$];
  logic rs[$];

  // Wire levels from both drivers
  assign dq_w = (d_dq_oe & d_dq) | (~d_dq_oe & c_dq);
  assign dqs_w = d_dqs_oe ? d_dqs : c_dqs;
  assign rd_data = 8'ha0 + nrd;

  ddp_pin_core i_ddp_pin_core (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .byte_wide_i(byte_wide), .diff_clock_true_i(ct), .diff_clock_comp_i(cc),
    .cmd_pins_i(pins), .addr_i(addr), .bank_i(bank), .termination_enable_i(termination_enable),
    .dq_i(dq_w), .dq_o(d_dq), .dq_oe_o(d_dq_oe), .dqs_i(dqs_w), .dqs_o(d_dqs),
    .dqs_n_o(d_dqs_n), .dqs_oe_o(d_dqs_oe), .write_mask_i(wm), .term_strobe_o(ts),
    .term_strobe_n_o(tsn), .term_strobe_oe_o(tsoe), .term_o(term), .wr_beat_o(beat),
    .rd_data_i(rd_data), .rd_take_o(rd_take), .cmd_o(cmd), .cmd_valid_o(cmd_valid));

  ddp_ctrl_model i_ddp_ctrl_model (.clk_sys_i(clk_sys_i), .diff_clock_true_o(ct),
    .diff_clock_comp_o(cc), .cmd_pins_o(pins), .addr_o(addr), .bank_o(bank),
    .termination_enable_o(termination_enable), .dq_o(c_dq), .dqs_o(c_dqs), .write_mask_o(wm));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) nrd <= 8'h00;
    else if (rd_take === 1'b1) nrd <= nrd + 8'h01;
  end

  // Collect write beats and read beats
  always @(negedge clk_sys_i) begin
    if (beat.valid === 1'b1) wq.push_back(beat.data);
    if (d_dqs_oe === 1'b1) begin
      rq.push_back(d_dq);
      rs.push_back(d_dqs);
      `CHK(d_dq_oe, 8'hff)
      `CHK(d_dqs_n, ~d_dqs)
    end
  end

  task automatic poll(output bit seen, output ddp_cmd_t c);
    seen = 1'b0;
    c = CMD_DESEL;
    repeat (3) begin
      if (cmd_valid === 1'b1) begin
        seen = 1'b1;
        c = cmd;
      end
      @(negedge clk_sys_i);
    end
  endtask

  task automatic tchk(input ddp_term_t e);
    repeat (3) @(negedge clk_sys_i);
    `CHK(term, e)
  endtask

  task automatic t_cmd();
    logic [3:0] codes [6] = '{4'h7, 4'h3, 4'h2, 4'h1, 4'h6, 4'h0};
    ddp_cmd_t exp [6] = '{CMD_NOP, CMD_ACT, CMD_PRE, CMD_REF, CMD_ZQ, CMD_MODE};
    bit seen;
    ddp_cmd_t c;
    for (int i = 0; i < 6; i++) begin
      i_ddp_ctrl_model.cmd(codes[i], 14'h0000, 3'h0, 1'b0);
      poll(seen, c);
      `CHK(seen, 1'b1)
      `CHK(c, exp[i])
    end
    i_ddp_ctrl_model.cmd(4'hb, 14'h0000, 3'h0, 1'b0);
    poll(seen, c);
    `CHK(seen, 1'b0)
    $display("test cmd done");
  endtask

  task automatic t_term();
    i_ddp_ctrl_model.cmd(4'h7, 14'h0000, 3'h0, 1'b1);
    tchk(12'hffe);
    i_ddp_ctrl_model.cmd(4'h7, 14'h0000, 3'h0, 1'b0);
    tchk(12'h000);
    i_ddp_ctrl_model.cmd(4'h0, 14'h0001, MR_TERM_BANK, 1'b1);
    i_ddp_ctrl_model.cmd(4'h7, 14'h0000, 3'h0, 1'b1);
    tchk(12'h000);
    i_ddp_ctrl_model.cmd(4'h0, 14'h0000, MR_TERM_BANK, 1'b0);
    $display("test term done");
  endtask

  task automatic t_write();
    wq.delete();
    i_ddp_ctrl_model.cmd(4'h4, 14'h0000, 3'h0, 1'b0);
    i_ddp_ctrl_model.wr(8'h30, 8'h04);
    repeat (2) @(negedge clk_sys_i);
    `CHK(wq.size(), 7)
    `CHK(wq[2], 8'h33)
    i_ddp_ctrl_model.cmd(4'h0, 14'h0800, MR_TERM_BANK, 1'b1);
    tchk(12'hfff);
    wq.delete();
    i_ddp_ctrl_model.cmd(4'h4, 14'h0000, 3'h0, 1'b1);
    i_ddp_ctrl_model.wr(8'h50, 8'hff);
    repeat (2) @(negedge clk_sys_i);
    `CHK(wq.size(), 8)
    `CHK(wq[7], 8'h57)
    `CHK({ts, tsn, tsoe}, 3'h0)
    i_ddp_ctrl_model.cmd(4'h0, 14'h0000, MR_TERM_BANK, 1'b0);
    $display("test write done");
  endtask

  task automatic t_read();
    logic [7:0] base;
    rq.delete();
    rs.delete();
    base = 8'ha0 + nrd;
    i_ddp_ctrl_model.cmd(4'h5, 14'h0000, 3'h0, 1'b0);
    repeat (12) @(negedge clk_sys_i);
    `CHK(rq.size(), 8)
    for (int i = 0; i < 8; i++) begin
      `CHK(rq[i], base + 8'(i))
      `CHK(rs[i], ~i[0])
    end
    $display("test read done");
  endtask

  task automatic t_reset();
    i_ddp_ctrl_model.cmd(4'h7, 14'h0000, 3'h0, 1'b1);
    tchk(12'hffe);
    #3;
    rst_n_i = 1'b0;
    #1;
    `CHK(term, 12'h000)
    byte_wide = 1'b0;
    #3;
    rst_n_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    i_ddp_ctrl_model.cmd(4'h7, 14'h0000, 3'h0, 1'b1);
    repeat (3) @(negedge clk_sys_i);
    `CHK(term.dq, 8'h0f)
    $display("test reset done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    #100us;
    n_mismatch++;
    results();
  end

  initial begin
    rst_n_i = 1'b1;
    byte_wide = 1'b1;
    n_mismatch = 0;
    checked = 0;
    #1;
    rst_n_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    t_cmd();
    t_term();
    t_write();
    t_read();
    t_reset();
    results();
  end
endmodule
